// >>> test/icl_host_model.sv
`default_nettype none
module icl_host_model #(
   parameter logic [6:0] ADDR = 7'h55
) (
   input wire logic sys_clk,
   input wire logic sda_oe,
   output logic scl,
   output wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   logic hold = 1'b0;
   logic r;
   // Open-drain data line with pull-up
   assign sda = !(hold || sda_oe);
   initial scl = 1'b1;
   // Third of a bit, longer than the minimum SCL phase
   task automatic q();
      repeat (5) @(negedge sys_clk);
   endtask
   // One bit, sampled at the end of SCL high
   task automatic bx(input logic b, output logic s);
      hold = !b;
      q();
      scl = 1'b1;
      q();
      s = sda;
      scl = 1'b0;
      q();
   endtask
   // Byte plus acknowledge slot
   task automatic bt(input logic [7:0] d, output logic [7:0] v);
      for (int i = 7; i >= 0; i--) bx(d[i], v[i]);
      bx(1'b1, r);
   endtask
   // Start or repeated start
   task automatic go();
      logic [7:0] x;
      hold = 1'b0;
      q();
      scl = 1'b1;
      q();
      hold = 1'b1;
      q();
      scl = 1'b0;
      q();
   endtask
   // Stop: data rises while the clock is high
   task automatic sp();
      hold = 1'b1;
      q();
      scl = 1'b1;
      q();
      hold = 1'b0;
      q();
   endtask
   // Write one or two bytes, optionally leaving out the stop
   task automatic wr(input logic [7:0] p, d, e, input logic two, fin);
      logic [7:0] x;
      go();
      bt({ADDR, 1'b0}, x);
      bt(p, x);
      bt(d, x);
      if (two) bt(e, x);
      if (fin) sp();
   endtask
   // Pointer write, repeated start, one byte read with final nack
   task automatic rd(input logic [7:0] p, output logic [7:0] v);
      logic [7:0] x;
      go();
      bt({ADDR, 1'b0}, x);
      bt(p, x);
      go();
      bt({ADDR, 1'b1}, x);
      bt(8'hff, v);
      sp();
   endtask
endmodule
`default_nettype wire

// >>> test/icl_regs_asserts.sv
`default_nettype none
module icl_regs_asserts (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic scl_in,
   input wire logic sense_resistor_select,
   input wire logic [6:0] low_ohm_code_limit,
   input wire logic adapter_present,
   input wire logic external_limit_enable,
   input wire logic external_limit_pin,
   input wire logic [6:0] host_input_current_limit,
   input wire logic [13:0] limit_ma,
   input wire logic limit_denotes_max,
   input wire logic use_external_loop
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Expected milliamps, code zero counts as one step
   function automatic logic [13:0] scale(input logic [6:0] c, input logic s);
      return (c == 7'h00 ? 14'h0001 : 14'(c)) * (s ? 14'h0064 : 14'h0032);
   endfunction
   // Adapter removed and kept away
   sequence s_removed;
      $fell(adapter_present) ##1 !adapter_present [*4];
   endsequence
   // External loop asked for with a steady pin
   sequence s_ext_on;
      (external_limit_enable && external_limit_pin) [*4];
   endsequence
   chk_reset_code: assert property ($fell(sys_rst) |-> host_input_current_limit == 7'h20)
      else $error("limit code not at reset value");
   chk_removal_load: assert property (s_removed |->
      host_input_current_limit == (sense_resistor_select ? 7'h20 : 7'h41))
      else $error("default not reloaded on adapter removal");
   chk_scaled_ma: assert property (!$past(sys_rst) |-> limit_ma ==
      scale($past(host_input_current_limit), $past(sense_resistor_select)))
      else $error("scaled limit wrong");
   chk_max_flag: assert property ($changed(sense_resistor_select) |=>
      limit_denotes_max == $past(sense_resistor_select))
      else $error("maximum flag does not follow select");
   chk_ext_off: assert property (!external_limit_enable |=> !use_external_loop)
      else $error("external loop used while disabled");
   chk_ext_on: assert property (s_ext_on |-> use_external_loop)
      else $error("external loop not taken");
   chk_commit_idle: assert property ($changed(host_input_current_limit) |->
      scl_in || !adapter_present)
      else $error("limit changed in mid transfer");
   chk_low_ohm_bound: assert property ($changed(host_input_current_limit) &&
      sense_resistor_select |-> host_input_current_limit <= low_ohm_code_limit)
      else $error("code above bound stored");
endmodule
`default_nettype wire

// >>> test/tb_icl_regs.sv
`default_nettype none
module tb_icl_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic sense_resistor_select = 1'b0;
   logic adapter_present = 1'b0;
   logic external_limit_enable = 1'b0;
   logic external_limit_pin = 1'b0;
   logic [6:0] low_ohm_code_limit = 7'h64;
   logic scl_in, sda_out, sda_oe, limit_denotes_max, use_external_loop;
   wire sda_in;
   logic [6:0] host_input_current_limit;
   logic [13:0] limit_ma;
   logic [7:0] v;
   int fails = 0;
   int tests_run = 0;
   logic [7:0] codes [8] = '{8'h00, 8'h01, 8'h41, 8'h7f, 8'h00, 8'h01, 8'h20, 8'h64};
   logic [13:0] mas [8] = '{14'h0032, 14'h0032, 14'h0cb2, 14'h18ce,
      14'h0064, 14'h0064, 14'h0c80, 14'h2710};
   always #12.5 sys_clk = !sys_clk;
   icl_regs DUT (.sys_clk, .sys_rst, .scl_in, .sda_in, .sda_out, .sda_oe, .sense_resistor_select,
      .low_ohm_code_limit, .adapter_present, .external_limit_enable, .external_limit_pin,
      .host_input_current_limit, .limit_ma, .limit_denotes_max, .use_external_loop);
   icl_host_model host (.sys_clk, .sda_oe, .scl(scl_in), .sda(sda_in));
   // Compare and count
   task automatic chk(input logic [13:0] s, input logic [13:0] e);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic finish_test();
      if (fails == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Register read with expected byte
   task automatic rdc(input logic [7:0] p, input logic [7:0] e);
      host.rd(p, v);
      chk(14'(v), 14'(e));
   endtask
   // Paired write of the limit, then settle
   task automatic lim(input logic [7:0] c);
      host.wr(8'h0e, 8'h00, c, 1'b1, 1'b1);
      repeat (4) @(negedge sys_clk);
   endtask
   // Hang guard
   initial begin
      repeat (100000) @(posedge sys_clk);
      fails++;
      finish_test();
   end
   // Main sequence
   initial begin
      repeat (6) @(negedge sys_clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge sys_clk);
      chk(limit_ma, 14'h0640);
      rdc(8'h0f, 8'h20);
      rdc(8'h30, 8'h00);
      for (int k = 0; k < 2; k++) begin
         rdc(8'h0e, 8'h00);
         rdc(8'h2e, 8'h3c);
         rdc(8'h2f, 8'h7a);
         host.wr(8'h0e, 8'hff, 8'h00, 1'b0, 1'b1);
         host.wr(8'h2e, 8'h00, 8'h11, 1'b1, 1'b1);
      end
      // Codes in both scalings
      for (int i = 0; i < 8; i++) begin
         sense_resistor_select = i[2];
         lim(codes[i]);
         rdc(8'h0f, codes[i]);
         chk(limit_ma, mas[i]);
      end
      lim(8'h65);
      rdc(8'h0f, 8'h64);
      lim(8'h85);
      rdc(8'h0f, 8'h64);
      host.wr(8'h0e, 8'h00, 8'h10, 1'b1, 1'b0);
      rdc(8'h0f, 8'h64);
      // Adapter removal in both scalings
      for (int s = 0; s < 2; s++) begin
         sense_resistor_select = s[0];
         lim(8'h10);
         adapter_present = 1'b1;
         repeat (4) @(negedge sys_clk);
         adapter_present = 1'b0;
         repeat (6) @(negedge sys_clk);
         chk(14'(host_input_current_limit), s ? 14'h0020 : 14'h0041);
         chk(limit_ma, s ? 14'h0c80 : 14'h0cb2);
         chk(14'(limit_ma + (s ? 14'h00c8 : 14'h0064)), s ? 14'h0d48 : 14'h0d16);
      end
      external_limit_pin = 1'b1;
      repeat (6) @(negedge sys_clk);
      chk(14'(use_external_loop), 14'h0000);
      external_limit_enable = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk(14'(use_external_loop), 14'h0001);
      finish_test();
   end
endmodule
bind icl_regs icl_regs_asserts u_chk (.sys_clk, .sys_rst, .scl_in, .sense_resistor_select,
   .low_ohm_code_limit, .adapter_present, .external_limit_enable, .external_limit_pin,
   .host_input_current_limit, .limit_ma, .limit_denotes_max, .use_external_loop);
`default_nettype wire

// >>> verilog/icl_pkg.sv
`default_nettype none
// Shared constants of the input current limit and identity register bank
package icl_pkg;
   // Register offsets on the serial bus
   localparam logic [7:0] LIMIT_LOW_OFFSET = 8'h0e;
   localparam logic [7:0] LIMIT_HIGH_OFFSET = 8'h0f;
   localparam logic [7:0] MAKER_OFFSET = 8'h2e;
   localparam logic [7:0] PART_OFFSET = 8'h2f;
   // Field layout of the upper limit byte
   localparam int LIMIT_CODE_WIDTH = 7;
   localparam int RESERVED_BIT = 7;
   // Reset, default and upper bound limit codes, fixed read values
   localparam logic [6:0] LIMIT_RESET_CODE = 7'h20;
   localparam logic [6:0] TEN_MOHM_DEFAULT_CODE = 7'h41;
   localparam logic [6:0] FIVE_MOHM_DEFAULT_CODE = 7'h20;
   localparam logic [6:0] TEN_MOHM_MAX_CODE = 7'h7f;
   localparam logic [7:0] LIMIT_LOW_VALUE = 8'h00;
   localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
   // Scaling in milliamps
   localparam int LIMIT_MA_WIDTH = 14;
   localparam logic [13:0] TEN_MOHM_STEP_MA = 14'h0032;
   localparam logic [13:0] FIVE_MOHM_STEP_MA = 14'h0064;
   localparam logic [13:0] TEN_MOHM_ZERO_MA = 14'h0032;
   localparam logic [13:0] FIVE_MOHM_ZERO_MA = 14'h0064;
   // Serial bus framing
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // Serial slave states
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_ADDR = 4'b0001,
      ST_ADDR_ACK = 4'b0010,
      ST_REG = 4'b0011,
      ST_REG_ACK = 4'b0100,
      ST_WDATA = 4'b0101,
      ST_WDATA_ACK = 4'b0110,
      ST_RDATA = 4'b0111,
      ST_RDATA_ACK = 4'b1000
   } icl_state_type;
endpackage
`default_nettype wire

// >>> verilog/icl_regs.sv
`default_nettype none
// Summary of operation
// R1: Low-ohm mode: code bits weighted 6400 mA down to 100 mA, summed.
// R2: Ten-milliohm mode: code scaled in 50 mA steps, 50 to 6350 mA.
// R3: Writes with code above the supported upper bound are discarded.
// R4: Ten-milliohm mode: code zero means 50 mA, no offset elsewhere.
// R5: Low-ohm mode: code zero means 100 mA, no offset elsewhere.
// R6: Ten-milliohm default 3.25 A, reloaded on adapter removal.
// R7: Low-ohm default 3.2 A, reloaded on removal; code denotes maximum.
// R8: Select bit 0 picks ten-milliohm, 1 picks low-ohm scaling and span.
// R9: Host adds 100 or 200 mA to nominal to get maximum limit.
// R10: External limit enable at 0 makes the device ignore that pin.
// R11: Upper byte bit 7 reserved, resets 0; writing 1 is invalid.
// R12: Lower byte is read-only, reads zero, ignores writes.
// R13: Maker identity at 2Eh returns a fixed code, writes ignored.
// R14: Part identity at 2Fh returns a fixed code, writes ignored.
// R15: Upper byte resets with only bit 5 set.
// R16: Host programs the limit as one 16-bit write across both bytes.
// R17: Upper byte reads return stored code, reserved bit reads zero.
// R18: Writes take effect only when the whole transfer ends with stop.
module icl_regs #(
   parameter logic [6:0] DEVICE_ADDRESS = 7'h55, // Arbitrary bus address
   parameter logic [7:0] MAKER_CODE = 8'h3c, // Arbitrary value
   parameter logic [7:0] PART_CODE = 8'h7a // Arbitrary value
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic sense_resistor_select,
   input wire logic [6:0] low_ohm_code_limit,
   input wire logic adapter_present,
   input wire logic external_limit_enable,
   input wire logic external_limit_pin,
   output logic [6:0] host_input_current_limit,
   output logic [13:0] limit_ma,
   output logic limit_denotes_max,
   output logic use_external_loop
);
   // Synchroniser and history flops for pins
   logic scl_meta, scl_sync, scl_prev;
   logic sda_meta, sda_sync, sda_prev;
   logic adp_meta, adp_sync, adp_prev;
   logic ext_meta, ext_sync;
   // Serial slave state
   icl_pkg::icl_state_type state;
   logic [7:0] shift;
   logic [3:0] bit_cnt;
   logic [7:0] pointer;
   logic read_mode;
   logic host_acked;
   logic [7:0] staged_high;
   logic staged_valid;
   logic drive_low;

   // Two-flop synchronisers, then one history stage except on the external limit pin
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         scl_prev <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
         sda_prev <= 1'b1;
         adp_meta <= 1'b0;
         adp_sync <= 1'b0;
         adp_prev <= 1'b0;
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
      end else begin
         scl_meta <= scl_in;
         scl_sync <= scl_meta;
         scl_prev <= scl_sync;
         sda_meta <= sda_in;
         sda_sync <= sda_meta;
         sda_prev <= sda_sync;
         adp_meta <= adapter_present;
         adp_sync <= adp_meta;
         adp_prev <= adp_sync;
         ext_meta <= external_limit_pin;
         ext_sync <= ext_meta;
      end
   end

   // Bus events
   wire scl_rise = scl_sync & ~scl_prev;
   wire scl_fall = ~scl_sync & scl_prev;
   wire bus_start = scl_sync & scl_prev & sda_prev & ~sda_sync;
   wire bus_stop = scl_sync & scl_prev & ~sda_prev & sda_sync;
   wire byte_done = (bit_cnt == icl_pkg::BITS_PER_BYTE);
   wire adapter_removed = adp_prev & ~adp_sync;

   // Read data selection
   wire [7:0] high_readback = {1'b0, host_input_current_limit}; // R17
   wire [7:0] read_data =
      (pointer == icl_pkg::LIMIT_LOW_OFFSET) ? icl_pkg::LIMIT_LOW_VALUE : // R12
      (pointer == icl_pkg::LIMIT_HIGH_OFFSET) ? high_readback :
      (pointer == icl_pkg::MAKER_OFFSET) ? MAKER_CODE : // R13
      (pointer == icl_pkg::PART_OFFSET) ? PART_CODE : // R14
      icl_pkg::UNMAPPED_VALUE;

   // Write validation at commit
   wire [6:0] code_bound = sense_resistor_select ? low_ohm_code_limit
                                                 : icl_pkg::TEN_MOHM_MAX_CODE; // R8
   wire reserved_set = staged_high[icl_pkg::RESERVED_BIT]; // R11
   wire code_ok = staged_high[6:0] <= code_bound; // R3
   wire commit = bus_stop & staged_valid & ~reserved_set & code_ok; // R18
   wire [6:0] default_code = sense_resistor_select ? icl_pkg::FIVE_MOHM_DEFAULT_CODE
                                                   : icl_pkg::TEN_MOHM_DEFAULT_CODE;

   // Serial slave sequencing
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= icl_pkg::ST_IDLE;
         shift <= 8'h00;
         bit_cnt <= 4'h0;
         pointer <= 8'h00;
         read_mode <= 1'b0;
         host_acked <= 1'b0;
         drive_low <= 1'b0;
      end else if (bus_stop) begin
         state <= icl_pkg::ST_IDLE;
         drive_low <= 1'b0;
      end else if (bus_start) begin
         state <= icl_pkg::ST_ADDR;
         bit_cnt <= 4'h0;
         drive_low <= 1'b0;
      end else begin
         case (state)
            icl_pkg::ST_ADDR, icl_pkg::ST_REG, icl_pkg::ST_WDATA: begin
               if (scl_rise && !byte_done) begin
                  shift <= {shift[6:0], sda_sync};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && byte_done) begin
                  bit_cnt <= 4'h0;
                  drive_low <= 1'b1;
                  if (state == icl_pkg::ST_ADDR) begin
                     if (shift[7:1] == DEVICE_ADDRESS) begin
                        read_mode <= shift[0];
                        state <= icl_pkg::ST_ADDR_ACK;
                     end else begin
                        drive_low <= 1'b0;
                        state <= icl_pkg::ST_IDLE;
                     end
                  end else if (state == icl_pkg::ST_REG) begin
                     pointer <= shift;
                     state <= icl_pkg::ST_REG_ACK;
                  end else begin
                     pointer <= pointer + 8'h01;
                     state <= icl_pkg::ST_WDATA_ACK;
                  end
               end
            end
            icl_pkg::ST_ADDR_ACK: begin
               if (scl_fall) begin
                  if (read_mode) begin
                     shift <= read_data;
                     drive_low <= ~read_data[7];
                     state <= icl_pkg::ST_RDATA;
                  end else begin
                     drive_low <= 1'b0;
                     state <= icl_pkg::ST_REG;
                  end
               end
            end
            icl_pkg::ST_REG_ACK, icl_pkg::ST_WDATA_ACK: begin
               if (scl_fall) begin
                  drive_low <= 1'b0;
                  state <= icl_pkg::ST_WDATA;
               end
            end
            icl_pkg::ST_RDATA: begin
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  if (byte_done) begin
                     drive_low <= 1'b0;
                     state <= icl_pkg::ST_RDATA_ACK;
                  end else begin
                     shift <= {shift[6:0], 1'b0};
                     drive_low <= ~shift[6];
                  end
               end
            end
            icl_pkg::ST_RDATA_ACK: begin
               if (scl_rise) begin
                  host_acked <= ~sda_sync;
                  pointer <= pointer + 8'h01;
               end else if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  if (host_acked) begin
                     shift <= read_data;
                     drive_low <= ~read_data[7];
                     state <= icl_pkg::ST_RDATA;
                  end else begin
                     state <= icl_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               drive_low <= 1'b0;
            end
         endcase
      end
   end

   // Staging of upper byte writes until stop
   wire stage_write = (state == icl_pkg::ST_WDATA) && scl_fall && byte_done
                      && !bus_start && !bus_stop;
   wire stage_high = stage_write && (pointer == icl_pkg::LIMIT_HIGH_OFFSET); // R16
   // Any start, repeated or not, abandons a write that never saw its stop
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         staged_high <= 8'h00;
         staged_valid <= 1'b0;
      end else if (bus_stop || bus_start) begin
         staged_valid <= 1'b0; // R18
      end else if (stage_high) begin
         staged_high <= shift;
         staged_valid <= 1'b1;
      end
   end

   // Stored limit code: removal reload wins over a commit
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         host_input_current_limit <= icl_pkg::LIMIT_RESET_CODE; // R15
      end else if (adapter_removed) begin
         host_input_current_limit <= default_code; // R6 R7
      end else if (commit) begin
         host_input_current_limit <= staged_high[6:0]; // R3 R11
      end
   end

   // Scaled limit in milliamps
   wire code_zero = (host_input_current_limit == 7'h00);
   wire [13:0] code_wide = {7'h00, host_input_current_limit};
   wire [13:0] ten_ma = code_zero ? icl_pkg::TEN_MOHM_ZERO_MA // R4
                                  : 14'(code_wide * icl_pkg::TEN_MOHM_STEP_MA); // R2
   wire [13:0] five_ma = code_zero ? icl_pkg::FIVE_MOHM_ZERO_MA // R5
                                   : 14'(code_wide * icl_pkg::FIVE_MOHM_STEP_MA); // R1
   wire [13:0] next_limit_ma = sense_resistor_select ? five_ma : ten_ma; // R8
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         limit_ma <= icl_pkg::FIVE_MOHM_ZERO_MA;
         limit_denotes_max <= 1'b0;
         use_external_loop <= 1'b0;
      end else begin
         limit_ma <= next_limit_ma;
         limit_denotes_max <= sense_resistor_select; // R7
         use_external_loop <= external_limit_enable & ext_sync; // R10
      end
   end

   // Open-drain data line: only ever pulled low
   assign sda_out = 1'b0;
   assign sda_oe = drive_low;
endmodule
`default_nettype wire
